/* File: hw/ebrw_regs.svh */
`ifndef EBRW_REGS_SVH
`define EBRW_REGS_SVH

// Register offsets
`define EBRW_OFS_TIMING 8'h00
`define EBRW_OFS_ADDR   8'h04
`define EBRW_OFS_WDATA  8'h08
`define EBRW_OFS_CMD    8'h0c
`define EBRW_OFS_STATUS 8'h10
`define EBRW_OFS_RDATA  8'h14

// Reset values
`define EBRW_TIMING_RST 16'h0001

// Command and status bits
`define EBRW_CMD_START  0
`define EBRW_CMD_WRITE  1
`define EBRW_CMD_BHE    2
`define EBRW_ST_BUSY    0

`endif

/* File: hw/ebrw_pkg.sv */
package ebrw_pkg;

    // Timing word, lsb first: ab, c, d, e-1, f, enable, async, polarity, mux
    typedef struct packed {
        logic       multiplexed_bus_mode;
        logic       rdy_pol_high;
        logic       rdy_async;
        logic       rdy_en;
        logic [1:0] f_len;
        logic [4:0] e_len_m1;
        logic       d_len;
        logic [1:0] c_len;
        logic [1:0] ab_len;
    } ebrw_cfg_type;

    typedef struct packed {
        logic        ale;
        logic        cs_n;
        logic        rd_n;
        logic        wr_n;
        logic        bhe_n;
        logic [23:0] addr;
        logic [15:0] ad_out;
        logic        ad_oe;
        logic [15:0] dq_out;
        logic        dq_oe;
    } ebrw_pins_type;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_AB   = 7'h02,
        ST_C    = 7'h04,
        ST_D    = 7'h08,
        ST_E    = 7'h10,
        ST_RDY  = 7'h20,
        ST_F    = 7'h40
    } ebrw_state_type;

endpackage

/* File: hw/ebrw_ctrl.sv */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ebrw_regs.svh"
module ebrw_ctrl (
    // System side
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Bus clock domain
    input  wire logic        bus_clk,
    output logic             reference_clock_out,
    // External bus pins
    output logic      [23:0] address_lines,
    input  wire logic [15:0] shared_addr_data_lines_in,
    output logic      [15:0] shared_addr_data_lines_out,
    output logic             shared_addr_data_lines_oe,
    input  wire logic [15:0] data_lines_in,
    output logic      [15:0] data_lines_out,
    output logic             data_lines_oe,
    output logic             byte_high_enable_n,
    output logic             chip_select_n,
    output logic             addr_latch_en,
    output logic             read_strobe_n,
    output logic             write_strobe_n,
    input  wire logic        handshake_in
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic rdy_active(input logic pin, input logic pol_high);
        rdy_active = (pin == pol_high);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // System clock side: registers and request handshake
    ebrw_pkg::ebrw_cfg_type cfg_q, cfg_d;
    logic [23:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic        write_q, write_d;
    logic        bhe_q, bhe_d;
    logic        busy_q, busy_d;
    logic        req_tgl_q, req_tgl_d;
    logic [15:0] rdata_q, rdata_d;
    logic [31:0] rd_q, rd_d;
    logic        dn_s1_q, dn_s2_q, dn_s3_q;
    logic        dn_seen_q, dn_seen_d;
    logic        done_tgl_q;
    logic [15:0] brd_q;
    logic        done_evt;

    always_comb begin
        cfg_d     = cfg_q;
        addr_d    = addr_q;
        wdata_d   = wdata_q;
        write_d   = write_q;
        bhe_d     = bhe_q;
        busy_d    = busy_q;
        req_tgl_d = req_tgl_q;
        rdata_d   = rdata_q;
        dn_seen_d = dn_seen_q;
        rd_d      = 32'h0;
        // Counts only once the last two stages agree
        done_evt  = (dn_s2_q == dn_s3_q) && (dn_s3_q != dn_seen_q);
        if (done_evt) begin
            busy_d    = 1'b0;
            rdata_d   = brd_q;
            dn_seen_d = dn_s3_q;
        end
        // Payload must stay still while the bus side reads it
        if (reg_wr && !busy_q) begin
            case (reg_addr)
                `EBRW_OFS_TIMING: begin
                    cfg_d = reg_wdata[15:0];
                end
                `EBRW_OFS_ADDR: begin
                    addr_d = reg_wdata[23:0];
                end
                `EBRW_OFS_WDATA: begin
                    wdata_d = reg_wdata[15:0];
                end
                `EBRW_OFS_CMD: begin
                    if (reg_wdata[`EBRW_CMD_START]) begin
                        write_d   = reg_wdata[`EBRW_CMD_WRITE];
                        bhe_d     = reg_wdata[`EBRW_CMD_BHE];
                        busy_d    = 1'b1;
                        req_tgl_d = ~req_tgl_q;
                    end
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `EBRW_OFS_TIMING: rd_d = {16'h0, cfg_q};
                `EBRW_OFS_ADDR:   rd_d = {8'h0, addr_q};
                `EBRW_OFS_WDATA:  rd_d = {16'h0, wdata_q};
                `EBRW_OFS_CMD:    rd_d = {29'h0, bhe_q, write_q, 1'b0};
                `EBRW_OFS_STATUS: rd_d = {31'h0, busy_q};
                `EBRW_OFS_RDATA:  rd_d = {16'h0, rdata_q};
                default:          rd_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q     <= `EBRW_TIMING_RST;
            addr_q    <= 24'h0;
            wdata_q   <= 16'h0;
            write_q   <= 1'b0;
            bhe_q     <= 1'b0;
            busy_q    <= 1'b0;
            req_tgl_q <= 1'b0;
            rdata_q   <= 16'h0;
            rd_q      <= 32'h0;
            dn_s1_q   <= 1'b0;
            dn_s2_q   <= 1'b0;
            dn_s3_q   <= 1'b0;
            dn_seen_q <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            addr_q    <= addr_d;
            wdata_q   <= wdata_d;
            write_q   <= write_d;
            bhe_q     <= bhe_d;
            busy_q    <= busy_d;
            req_tgl_q <= req_tgl_d;
            rdata_q   <= rdata_d;
            rd_q      <= rd_d;
            dn_s1_q   <= done_tgl_q;
            dn_s2_q   <= dn_s1_q;
            dn_s3_q   <= dn_s2_q;
            dn_seen_q <= dn_seen_d;
        end
    end

    assign reg_rdata = rd_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus clock side: phase sequencer
    ebrw_pkg::ebrw_state_type st_q, st_d;
    ebrw_pkg::ebrw_pins_type  pins_q, pins_d;
    logic [4:0]  cnt_q, cnt_d;
    logic        rq_s1_q, rq_s2_q, rq_s3_q;
    logic        rq_seen_q, rq_seen_d;
    logic        done_tgl_d;
    logic [15:0] brd_d;
    logic        rdy_s_q;
    logic        rdy_a1_q, rdy_a2_q;
    logic        go;
    logic        rdy_ok;
    logic        acc_end;
    logic        in_cmd;
    logic        in_wdat;

    // Reference clock is the sequencer's own clock
    assign reference_clock_out = bus_clk;

    always_comb begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        rq_seen_d  = rq_seen_q;
        done_tgl_d = done_tgl_q;
        brd_d      = brd_q;
        acc_end    = 1'b0;
        go         = (rq_s2_q == rq_s3_q) && (rq_s3_q != rq_seen_q);
        // Async path sampled one flop later than sync path
        rdy_ok     = cfg_q.rdy_async ? rdy_active(rdy_a2_q, cfg_q.rdy_pol_high)
                                     : rdy_active(rdy_s_q, cfg_q.rdy_pol_high);
        case (st_q)
            ebrw_pkg::ST_IDLE: begin
                if (go) begin
                    rq_seen_d = rq_s3_q;
                    st_d      = ebrw_pkg::ST_AB;
                    cnt_d     = (cfg_q.ab_len == 2'h0) ? 5'h0 : {3'h0, cfg_q.ab_len - 2'h1};
                end
            end
            ebrw_pkg::ST_AB: begin
                if (cnt_q != 5'h0) begin
                    cnt_d = cnt_q - 5'h1;
                end else if (cfg_q.c_len != 2'h0) begin
                    st_d  = ebrw_pkg::ST_C;
                    cnt_d = {3'h0, cfg_q.c_len - 2'h1};
                end else if (cfg_q.d_len) begin
                    st_d  = ebrw_pkg::ST_D;
                    cnt_d = 5'h0;
                end else begin
                    st_d  = ebrw_pkg::ST_E;
                    cnt_d = cfg_q.e_len_m1;
                end
            end
            ebrw_pkg::ST_C: begin
                if (cnt_q != 5'h0) begin
                    cnt_d = cnt_q - 5'h1;
                end else if (cfg_q.d_len) begin
                    st_d  = ebrw_pkg::ST_D;
                    cnt_d = 5'h0;
                end else begin
                    st_d  = ebrw_pkg::ST_E;
                    cnt_d = cfg_q.e_len_m1;
                end
            end
            ebrw_pkg::ST_D: begin
                st_d  = ebrw_pkg::ST_E;
                cnt_d = cfg_q.e_len_m1;
            end
            ebrw_pkg::ST_E: begin
                if (cnt_q != 5'h0) begin
                    cnt_d = cnt_q - 5'h1;
                end else if (!cfg_q.rdy_en) begin
                    acc_end = 1'b1;
                end else if (cfg_q.rdy_async) begin
                    st_d = ebrw_pkg::ST_RDY;
                end else if (rdy_ok) begin
                    acc_end = 1'b1;
                end else begin
                    st_d = ebrw_pkg::ST_RDY;
                end
            end
            ebrw_pkg::ST_RDY: begin
                // Each cycle here is one handshake wait state
                if (rdy_ok) begin
                    acc_end = 1'b1;
                end
            end
            ebrw_pkg::ST_F: begin
                if (cnt_q != 5'h0) begin
                    cnt_d = cnt_q - 5'h1;
                end else begin
                    st_d       = ebrw_pkg::ST_IDLE;
                    done_tgl_d = ~done_tgl_q;
                end
            end
            default: begin
                st_d = ebrw_pkg::ST_IDLE;
            end
        endcase
        if (acc_end) begin
            // Latched on the edge that raises the strobe
            brd_d = cfg_q.multiplexed_bus_mode ? shared_addr_data_lines_in : data_lines_in;
            if (cfg_q.f_len != 2'h0) begin
                st_d  = ebrw_pkg::ST_F;
                cnt_d = {3'h0, cfg_q.f_len - 2'h1};
            end else begin
                st_d       = ebrw_pkg::ST_IDLE;
                done_tgl_d = ~done_tgl_q;
            end
        end
    end

    // Pin values follow the next state so they leave flops
    always_comb begin
        in_cmd  = (st_d == ebrw_pkg::ST_E) || (st_d == ebrw_pkg::ST_RDY);
        in_wdat = write_q && (in_cmd || (st_d == ebrw_pkg::ST_D) || (st_d == ebrw_pkg::ST_F));
        pins_d.ale    = (st_d == ebrw_pkg::ST_AB);
        pins_d.cs_n   = (st_d == ebrw_pkg::ST_IDLE);
        pins_d.rd_n   = !(in_cmd && !write_q);
        pins_d.wr_n   = !(in_cmd && write_q);
        pins_d.bhe_n  = !(bhe_q && (st_d != ebrw_pkg::ST_IDLE));
        pins_d.addr   = addr_q;
        pins_d.ad_out = 16'h0;
        pins_d.ad_oe  = 1'b0;
        pins_d.dq_out = wdata_q;
        pins_d.dq_oe  = 1'b0;
        if (cfg_q.multiplexed_bus_mode) begin
            if ((st_d == ebrw_pkg::ST_AB) || (st_d == ebrw_pkg::ST_C)) begin
                pins_d.ad_out = addr_q[15:0];
                pins_d.ad_oe  = 1'b1;
            end else if (in_wdat) begin
                pins_d.ad_out = wdata_q;
                pins_d.ad_oe  = 1'b1;
            end
        end else begin
            pins_d.dq_oe = in_wdat;
        end
    end

    always_ff @(posedge bus_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q       <= ebrw_pkg::ST_IDLE;
            cnt_q      <= 5'h0;
            rq_s1_q    <= 1'b0;
            rq_s2_q    <= 1'b0;
            rq_s3_q    <= 1'b0;
            rq_seen_q  <= 1'b0;
            done_tgl_q <= 1'b0;
            brd_q      <= 16'h0;
            rdy_s_q    <= 1'b0;
            rdy_a1_q   <= 1'b0;
            rdy_a2_q   <= 1'b0;
            pins_q     <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, bhe_n: 1'b1, default: '0};
        end else begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            rq_s1_q    <= req_tgl_q;
            rq_s2_q    <= rq_s1_q;
            rq_s3_q    <= rq_s2_q;
            rq_seen_q  <= rq_seen_d;
            done_tgl_q <= done_tgl_d;
            brd_q      <= brd_d;
            rdy_s_q    <= handshake_in;
            rdy_a1_q   <= handshake_in;
            rdy_a2_q   <= rdy_a1_q;
            pins_q     <= pins_d;
        end
    end

    assign address_lines              = pins_q.addr;
    assign shared_addr_data_lines_out = pins_q.ad_out;
    assign shared_addr_data_lines_oe  = pins_q.ad_oe;
    assign data_lines_out             = pins_q.dq_out;
    assign data_lines_oe              = pins_q.dq_oe;
    assign byte_high_enable_n         = pins_q.bhe_n;
    assign chip_select_n              = pins_q.cs_n;
    assign addr_latch_en              = pins_q.ale;
    assign read_strobe_n              = pins_q.rd_n;
    assign write_strobe_n             = pins_q.wr_n;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge bus_clk); endclocking
    default disable iff (!arst_n);

    sequence s_e_last;
        st_q == ebrw_pkg::ST_E && cnt_q == 5'h0 && cfg_q.rdy_en;
    endsequence

    sequence s_rdy_hit;
        st_q == ebrw_pkg::ST_RDY && rdy_ok;
    endsequence

    chk_wait_inserted: assert property (
        s_e_last ##0 (!cfg_q.rdy_async && !rdy_ok) |=> st_q == ebrw_pkg::ST_RDY
    ) else $error("no wait state after inactive handshake");

    chk_ready_ends: assert property (
        s_rdy_hit |=> (st_q == ebrw_pkg::ST_F || st_q == ebrw_pkg::ST_IDLE)
            && read_strobe_n && write_strobe_n
    ) else $error("access not ended on active handshake");

    chk_async_extra: assert property (
        s_e_last ##0 cfg_q.rdy_async |=> st_q == ebrw_pkg::ST_RDY
    ) else $error("asynchronous mode missed its wait state");

    chk_mandatory_first: assert property (
        st_q == ebrw_pkg::ST_E && cnt_q != 5'h0 |=> st_q == ebrw_pkg::ST_E
    ) else $error("access left before mandatory wait states");

    chk_access_load: assert property (
        $changed(st_q) && st_q == ebrw_pkg::ST_E |-> cnt_q == cfg_q.e_len_m1
    ) else $error("access length not loaded");

    chk_ignore_off: assert property (
        st_q == ebrw_pkg::ST_E && cnt_q == 5'h0 && !cfg_q.rdy_en
            |=> st_q != ebrw_pkg::ST_RDY ##1 st_q != ebrw_pkg::ST_RDY
    ) else $error("handshake used while disabled");

    chk_read_capture: assert property (
        (st_q == ebrw_pkg::ST_E || st_q == ebrw_pkg::ST_RDY) && !write_q && acc_end
            |=> $rose(read_strobe_n)
            && brd_q == (cfg_q.multiplexed_bus_mode ? $past(shared_addr_data_lines_in) : $past(data_lines_in))
    ) else $error("read data not taken with strobe rise");

    chk_mux_address: assert property (
        cfg_q.multiplexed_bus_mode && st_q == ebrw_pkg::ST_AB
            |-> shared_addr_data_lines_oe && shared_addr_data_lines_out == addr_q[15:0]
    ) else $error("shared lines miss address");

    chk_separate_bus_mode_wdata: assert property (
        !cfg_q.multiplexed_bus_mode && write_q && st_q == ebrw_pkg::ST_E
            |-> data_lines_oe && data_lines_out == wdata_q && !shared_addr_data_lines_oe
    ) else $error("data lines miss write data");

    chk_strobe_access: assert property (
        (st_q == ebrw_pkg::ST_AB || st_q == ebrw_pkg::ST_C || st_q == ebrw_pkg::ST_F)
            |-> read_strobe_n && write_strobe_n
    ) else $error("strobe outside access phase");

endmodule

/* File: verif/ebrw_ext_model.sv */
`timescale 1ns/1ps
module ebrw_ext_model (
    // Bus pins
    input  wire logic        reference_clock_out,
    input  wire logic        chip_select_n,
    input  wire logic        addr_latch_en,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [15:0] shared_addr_data_lines_out,
    input  wire logic [15:0] data_lines_out,
    input  wire logic        byte_high_enable_n,
    output logic             handshake_in,
    output logic      [15:0] shared_addr_data_lines_in,
    output logic      [15:0] data_lines_in,
    // Scenario control
    input  wire logic [5:0]  waits,
    input  wire logic        pol_high,
    input  wire logic        multiplexed_bus_mode,
    input  wire logic [15:0] rd_val,
    // Observations
    output logic      [15:0] lat_addr,
    output logic      [15:0] wr_data,
    output logic      [7:0]  lead_len,
    output logic      [7:0]  strobe_len,
    output logic      [7:0]  hold_len,
    output logic             bhe_seen
);
    logic [7:0] cnt_q;
    logic [7:0] tick_q;
    logic [7:0] t_cs;
    logic [7:0] t_st;
    logic [7:0] t_sr;
    logic       hs_act_q;
    logic       cs_prev;
    logic       st_prev;
    logic       strobe_n;

    assign strobe_n = read_strobe_n & write_strobe_n;
    // Active level follows the programmed polarity
    assign handshake_in = pol_high ? hs_act_q : ~hs_act_q;
    // Released lines show the inverse, so a stale value can never pass
    assign data_lines_in = read_strobe_n ? ~rd_val : rd_val;
    assign shared_addr_data_lines_in = (read_strobe_n | ~multiplexed_bus_mode) ? ~rd_val : rd_val;

    initial begin
        cnt_q    = 8'h00;
        tick_q   = 8'h00;
        hs_act_q = 1'b0;
        cs_prev  = 1'b1;
        st_prev  = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge reference_clock_out) begin
        tick_q  <= tick_q + 8'h01;
        cs_prev <= chip_select_n;
        st_prev <= strobe_n;
        if (cs_prev && !chip_select_n) begin
            t_cs <= tick_q;
        end
        if (st_prev && !strobe_n) begin
            t_st     <= tick_q;
            lead_len <= tick_q - t_cs;
        end
        if (!st_prev && strobe_n) begin
            t_sr       <= tick_q;
            strobe_len <= tick_q - t_st;
        end
        if (!cs_prev && chip_select_n) begin
            hold_len <= (!st_prev && strobe_n) ? 8'h00 : tick_q - t_sr;
        end
        // Handshake changes only on the reference clock edge
        if (!strobe_n) begin
            cnt_q    <= cnt_q + 8'h01;
            hs_act_q <= ((cnt_q + 8'h01) >= {2'b00, waits});
        end else begin
            cnt_q    <= 8'h00;
            hs_act_q <= 1'b0;
        end
        if (addr_latch_en) begin
            lat_addr <= shared_addr_data_lines_out;
        end
        if (!write_strobe_n) begin
            wr_data <= multiplexed_bus_mode ? shared_addr_data_lines_out : data_lines_out;
        end
        // Byte enable must stand while the command strobe is low
        if (!strobe_n) begin
            bhe_seen <= byte_high_enable_n;
        end
    end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`include "ebrw_regs.svh"
module tb_top;
    logic        clk, arst_n, bus_clk, reg_wr, reg_rd, ref_clk, rdy, bhe_n, cs_n, ale;
    logic        rd_n, wr_n, sh_oe, dq_oe, pol_high, multiplexed_bus_mode, bhe_seen;
    logic [7:0]  reg_addr, lead_len, strobe_len, hold_len;
    logic [31:0] reg_wdata, reg_rdata;
    logic [23:0] addr;
    logic [15:0] sh_in, sh_out, dq_in, dq_out, rd_val, lat_addr, wr_data;
    logic [5:0]  waits;
    int          miscompares, n_compared;
    integer      seed;

    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    initial bus_clk = 1'b0;
    always #32 bus_clk = ~bus_clk;

    ebrw_ctrl ebrw_ctrl_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus_clk(bus_clk), .reference_clock_out(ref_clk), .address_lines(addr),
        .shared_addr_data_lines_in(sh_in), .shared_addr_data_lines_out(sh_out),
        .shared_addr_data_lines_oe(sh_oe), .data_lines_in(dq_in), .data_lines_out(dq_out),
        .data_lines_oe(dq_oe), .byte_high_enable_n(bhe_n), .chip_select_n(cs_n),
        .addr_latch_en(ale), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .handshake_in(rdy));

    ebrw_ext_model ebrw_ext_model_i (.reference_clock_out(ref_clk), .chip_select_n(cs_n),
        .addr_latch_en(ale), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .shared_addr_data_lines_out(sh_out), .data_lines_out(dq_out), .handshake_in(rdy),
        .shared_addr_data_lines_in(sh_in), .data_lines_in(dq_in), .waits(waits),
        .pol_high(pol_high), .multiplexed_bus_mode(multiplexed_bus_mode), .rd_val(rd_val), .lat_addr(lat_addr),
        .wr_data(wr_data), .lead_len(lead_len), .strobe_len(strobe_len),
        .hold_len(hold_len), .byte_high_enable_n(bhe_n), .bhe_seen(bhe_seen));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Phase lengths as programmed; a zero address phase still takes one cycle
    function automatic logic [31:0] lead_exp(input ebrw_pkg::ebrw_cfg_type c);
        return 32'((c.ab_len == 2'b00) ? 2'b01 : c.ab_len) + 32'(c.c_len) + 32'(c.d_len);
    endfunction

    task automatic run_cycle(input ebrw_pkg::ebrw_cfg_type c, input logic [23:0] a,
                             input logic [15:0] wd, input logic wr, input logic bh,
                             output logic [7:0] len);
        logic [31:0] st;
        int          n;
        @(posedge clk);
        pol_high <= c.rdy_pol_high;
        multiplexed_bus_mode      <= c.multiplexed_bus_mode;
        reg_write(`EBRW_OFS_TIMING, {16'h0000, c});
        reg_write(`EBRW_OFS_ADDR, {8'h00, a});
        reg_write(`EBRW_OFS_WDATA, {16'h0000, wd});
        reg_write(`EBRW_OFS_CMD, {29'h0, bh, wr, 1'b1});
        // Busy already set: this write must be dropped
        reg_write(`EBRW_OFS_ADDR, {8'h00, ~a});
        st = 32'h1;
        n  = 0;
        while (st[`EBRW_ST_BUSY] !== 1'b0 && n < 600) begin
            reg_read(`EBRW_OFS_STATUS, st);
            n++;
        end
        check(32'(n < 600), 32'h1, "busy stuck");
        check({28'h0, cs_n, rd_n, wr_n, bhe_n}, 32'hf, "idle strobes");
        check({30'h0, sh_oe, dq_oe}, 32'h0, "lines released");
        check({8'h00, addr}, {8'h00, a}, "address lines");
        check({24'h0, lead_len}, lead_exp(c), "lead phases");
        check({24'h0, hold_len}, 32'(c.f_len), "hold phase");
        if (c.multiplexed_bus_mode) begin
            check({16'h0, lat_addr}, {16'h0, a[15:0]}, "muxed address");
        end
        if (wr) begin
            check({16'h0, wr_data}, {16'h0, wd}, "write data");
        end else begin
            reg_read(`EBRW_OFS_RDATA, st);
            check(st, {16'h0, rd_val}, "read data");
        end
        check({31'h0, bhe_seen}, {31'h0, ~bh}, "byte high enable");
        len = strobe_len;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        miscompares++;
        final_report();
    end

    initial begin
        ebrw_pkg::ebrw_cfg_type c;
        logic [31:0] r, lo, e;
        logic [7:0]  len, len_sync;
        seed = 32'h1544;
        {arst_n, reg_wr, reg_rd, pol_high, multiplexed_bus_mode} = 5'b00000;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        waits     = 6'h00;
        rd_val    = 16'h5aa5;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        reg_read(`EBRW_OFS_TIMING, r);
        check(r, 32'h0000_0001, "timing reset");
        reg_read(8'hfc, r);
        check(r, 32'h0, "unmapped read");
        // Longest access with the handshake off: pin held ready-inactive
        c = 16'h03ff;
        waits <= 6'h3f;
        run_cycle(c, 24'hffffff, 16'hffff, 1'b0, 1'b1, len);
        check({24'h0, len}, 32'd32, "max access");
        // Same cycle, synchronous then asynchronous handshake
        for (int m = 0; m < 2; m++) begin
            c = 16'h1044;
            c.rdy_async = m[0];
            waits <= 6'h02;
            run_cycle(c, 24'h123456, 16'h8001, 1'b1, 1'b0, len);
            if (m == 1) begin
                check(32'(len > len_sync), 32'h1, "async later");
            end
            len_sync = len;
        end
        repeat (30) begin
            r = $random(seed);
            c = r[15:0];
            c.e_len_m1 = {2'b00, r[7:5]};
            e = 32'(c.e_len_m1) + 32'h1;
            waits  <= c.rdy_en ? {2'b00, r[19:16]} : 6'h3f;
            rd_val <= r[31:16];
            run_cycle(c, 24'($random(seed)), 16'($random(seed)), r[20], r[21], len);
            if (!c.rdy_en) begin
                check({24'h0, len}, e, "fixed access");
            end else begin
                lo = e + 32'(c.rdy_async);
                lo = (lo > 32'(r[19:16])) ? lo : 32'(r[19:16]);
                check(32'(len >= lo && len <= lo + 4), 32'h1, "stretched access");
                check(32'(len >= e), 32'h1, "mandatory waits");
            end
        end
        final_report();
    end
endmodule
